//--- rtl/dgoc_engine.v
// dac gain and offset correction engine: trim storage, register access,
// per-dac corrected words for two channels of four level dacs each
// assumes a register access port driven by spi logic on the same clock
//
// Notes on behaviour
// - each level dac has its own 16-bit gain and offset trim register.
// - shared dacs keep one trim pair per mode; the active mode picks it.
// - trims are volatile, reset to defaults; host reloads after power-up.
// - control bit 0 clear bypasses correction for all dacs on their next input word write.
// - corrected = (gain+1)*input/2^16 + offset - 2^15, 16-bit resolution.
// - gain trims reset to all ones, giving unity gain.
// - offset trims reset to mid-scale, giving zero offset.
// - corrected word drives the dac and is returned on data reads.
// - only input word writes recompute; trim writes leave words alone.
// - a dual-channel write updates both words in turn with own trims.
// - one corrected-word register per physical dac, none per mode.
// - offset is added in raw lsb units after gain scaling.
// - the gain factor never exceeds one.
`timescale 1ns/1ps
`include "dgoc_consts.vh"

module dgoc_engine (
   input  wire                         mclk_in,
   input  wire                         srst_in,
   input  wire                         ce_in,
   input  wire                         wr_en_in,
   input  wire                         rd_en_in,
   input  wire [1:0]                   ch_sel_in,
   input  wire [`DGOC_AW-1:0]          addr_in,
   input  wire [`DGOC_W-1:0]           wdata_in,
   output reg  [`DGOC_W-1:0]           rdata_out,
   output reg                          rdata_valid_out,
   output reg                          busy_out,
   output reg                          word_update_out,
   output wire [8*`DGOC_W-1:0]         corrected_dac_word_out
);

   localparam ST_IDLE   = 2'b01;
   localparam ST_SECOND = 2'b10;

   reg  [1:0]            state;
   reg                   cal_en;
   reg  [`DGOC_LVLS-1:0] mode_ch0;
   reg  [`DGOC_LVLS-1:0] mode_ch1;
   reg  [`DGOC_W-1:0]    gain_trim [0:`DGOC_TRIMS-1];
   reg  [`DGOC_W-1:0]    offset_trim [0:`DGOC_TRIMS-1];
   reg  [`DGOC_W-1:0]    dac_word [0:7];
   reg  [1:0]            pend_lvl;
   reg  [`DGOC_W-1:0]    pend_raw;

   wire                  hit_dac;
   wire                  hit_gain;
   wire                  hit_offs;
   wire                  calc_go;
   wire                  calc_ch;
   wire [1:0]            calc_lvl;
   wire [`DGOC_W-1:0]    calc_raw;
   wire [3:0]            calc_idx;
   wire [`DGOC_W-1:0]    calc_out;
   wire                  rd_ch;
   integer               i;
   genvar                g;

   ////////////////////////////////////////////////////////////////////////////
   // decode

   // trim slot for a channel, mode and level
   function [3:0] trim_idx;
      input       ch;
      input       mode;
      input [1:0] lvl;
      begin
         trim_idx = {ch, mode, lvl};
      end
   endfunction

   // mode bit of a level on a channel
   function mode_of;
      input       ch;
      input [1:0] lvl;
      input [3:0] m0;
      input [3:0] m1;
      begin
         if (ch) begin
            mode_of = m1[lvl];
         end else begin
            mode_of = m0[lvl];
         end
      end
   endfunction

   assign hit_dac  = (addr_in[7:2] == `DGOC_DAC_HI);
   assign hit_gain = (addr_in[7:3] == `DGOC_GAIN_HI);
   assign hit_offs = (addr_in[7:3] == `DGOC_OFFS_HI);
   assign rd_ch    = ~ch_sel_in[0] & ch_sel_in[1];

   ////////////////////////////////////////////////////////////////////////////
   // correction datapath, shared by both channels one after the other

   assign calc_go  = (state == ST_SECOND) |
                     (wr_en_in & hit_dac & (ch_sel_in != 2'b00) & ~busy_out);
   assign calc_ch  = (state == ST_SECOND) ? 1'b1 : ~ch_sel_in[0];
   assign calc_lvl = (state == ST_SECOND) ? pend_lvl : addr_in[1:0];
   assign calc_raw = (state == ST_SECOND) ? pend_raw : wdata_in;
   // active mode selects the trim pair
   assign calc_idx = trim_idx(calc_ch, mode_of(calc_ch, calc_lvl, mode_ch0, mode_ch1),
                              calc_lvl);

   dgoc_corr u_corr (
      .raw_level_word_in      (calc_raw),
      .gain_in                (gain_trim[calc_idx]),
      .offset_in              (offset_trim[calc_idx]),
      .cal_en_in              (cal_en),
      .corrected_dac_word_out (calc_out)
   );

   ////////////////////////////////////////////////////////////////////////////
   // sequencer and register writes

   always @(posedge mclk_in) begin
      if (srst_in) begin
         state           <= ST_IDLE;
         busy_out        <= 1'b0;
         word_update_out <= 1'b0;
         pend_lvl        <= 2'b00;
         pend_raw        <= `DGOC_WORD_RST;
         cal_en          <= `DGOC_CTRL_RST;
         mode_ch0        <= 4'h0;
         mode_ch1        <= 4'h0;
         for (i = 0; i < `DGOC_TRIMS; i = i + 1) begin
            gain_trim[i]   <= `DGOC_GAIN_RST;
            offset_trim[i] <= `DGOC_OFFS_RST;
         end
         for (i = 0; i < 8; i = i + 1) begin
            dac_word[i] <= `DGOC_WORD_RST;
         end
      end else if (ce_in) begin
         word_update_out <= calc_go;
         // one word register per dac, whatever the mode
         if (calc_go) begin
            dac_word[{calc_ch, calc_lvl}] <= calc_out;
         end
         case (state)
            ST_IDLE: begin
               if (calc_go && ch_sel_in == 2'b11) begin
                  state    <= ST_SECOND;
                  busy_out <= 1'b1;
                  pend_lvl <= addr_in[1:0];
                  pend_raw <= wdata_in;
               end
            end
            ST_SECOND: begin
               state    <= ST_IDLE;
               busy_out <= 1'b0;
            end
            default: begin
               state    <= ST_IDLE;
               busy_out <= 1'b0;
            end
         endcase
         // trim and mode writes never touch the dac words
         if (wr_en_in && !busy_out) begin
            if (addr_in == `DGOC_ADDR_CTRL) begin
               cal_en <= wdata_in[`DGOC_CAL_EN_BIT];
            end else if (addr_in == `DGOC_ADDR_MODE) begin
               if (ch_sel_in[0]) begin
                  mode_ch0 <= wdata_in[`DGOC_LVLS-1:0];
               end
               if (ch_sel_in[1]) begin
                  mode_ch1 <= wdata_in[`DGOC_LVLS-1:0];
               end
            end else if (hit_gain) begin
               if (ch_sel_in[0]) begin
                  gain_trim[trim_idx(1'b0, addr_in[2], addr_in[1:0])] <= wdata_in;
               end
               if (ch_sel_in[1]) begin
                  gain_trim[trim_idx(1'b1, addr_in[2], addr_in[1:0])] <= wdata_in;
               end
            end else if (hit_offs) begin
               if (ch_sel_in[0]) begin
                  offset_trim[trim_idx(1'b0, addr_in[2], addr_in[1:0])] <= wdata_in;
               end
               if (ch_sel_in[1]) begin
                  offset_trim[trim_idx(1'b1, addr_in[2], addr_in[1:0])] <= wdata_in;
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register reads, one cycle after the request

   always @(posedge mclk_in) begin
      if (srst_in) begin
         rdata_out       <= `DGOC_WORD_RST;
         rdata_valid_out <= 1'b0;
      end else if (ce_in) begin
         rdata_valid_out <= rd_en_in;
         if (rd_en_in) begin
            if (addr_in == `DGOC_ADDR_CTRL) begin
               rdata_out <= {15'h0000, cal_en};
            end else if (addr_in == `DGOC_ADDR_MODE) begin
               rdata_out <= rd_ch ? {12'h000, mode_ch1} : {12'h000, mode_ch0};
            end else if (hit_dac) begin
               rdata_out <= dac_word[{rd_ch, addr_in[1:0]}];
            end else if (hit_gain) begin
               rdata_out <= gain_trim[trim_idx(rd_ch, addr_in[2], addr_in[1:0])];
            end else if (hit_offs) begin
               rdata_out <= offset_trim[trim_idx(rd_ch, addr_in[2], addr_in[1:0])];
            end else begin
               rdata_out <= `DGOC_WORD_RST;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // words applied to the dacs

   generate
      for (g = 0; g < 8; g = g + 1) begin : g_out
         assign corrected_dac_word_out[g*`DGOC_W +: `DGOC_W] = dac_word[g];
      end
   endgenerate

endmodule

//--- rtl/dgoc_consts.vh
// constants for the dac gain and offset correction engine
// assumes inclusion by every design file of the block
`ifndef DGOC_CONSTS_VH
`define DGOC_CONSTS_VH

`define DGOC_W            16
`define DGOC_AW           8
`define DGOC_LVLS         4
`define DGOC_TRIMS        16
`define DGOC_ADDR_CTRL    8'h11
`define DGOC_ADDR_MODE    8'h12
`define DGOC_DAC_HI       6'h00
`define DGOC_GAIN_HI      5'h08
`define DGOC_OFFS_HI      5'h0c
`define DGOC_CAL_EN_BIT   0
`define DGOC_CTRL_RST     1'b1
`define DGOC_GAIN_RST     16'hffff
`define DGOC_OFFS_RST     16'h8000
`define DGOC_WORD_RST     16'h0000
`define DGOC_MID          19'sh08000
`define DGOC_MAX          19'sh0ffff

`endif

//--- rtl/dgoc_corr.v
// corrected word arithmetic: gain scaling, offset, saturation, bypass
// assumes inputs are stable registers of the same clock; purely combinational
`timescale 1ns/1ps
`include "dgoc_consts.vh"

module dgoc_corr (
   input  wire [`DGOC_W-1:0] raw_level_word_in,
   input  wire [`DGOC_W-1:0] gain_in,
   input  wire [`DGOC_W-1:0] offset_in,
   input  wire               cal_en_in,
   output reg  [`DGOC_W-1:0] corrected_dac_word_out
);

   wire [`DGOC_W:0]       gain_plus;
   wire [2*`DGOC_W:0]     product;
   wire [`DGOC_W:0]       scaled;
   wire signed [18:0]     sum;

   assign gain_plus = {1'b0, gain_in} + 17'h00001; // never above 2^16, gain <= 1
   assign product   = gain_plus * {17'h00000, raw_level_word_in};
   // drop the low half of the product, truncating toward zero
   assign scaled    = product[2*`DGOC_W:`DGOC_W];
   // offset added in raw lsb units after scaling
   assign sum       = $signed({2'b00, scaled}) + $signed({3'b000, offset_in}) - `DGOC_MID;

   always @* begin
      if (!cal_en_in) begin
         corrected_dac_word_out = raw_level_word_in;
      end else if (sum < 19'sh00000) begin
         corrected_dac_word_out = 16'h0000;
      end else if (sum > `DGOC_MAX) begin
         corrected_dac_word_out = 16'hffff;
      end else begin
         corrected_dac_word_out = sum[`DGOC_W-1:0];
      end
   end

endmodule

//--- test/dgoc_engine_checker.sv
// assertions on the register port of the correction engine
// assumes one clock, synchronous reset, bound to dgoc_engine
`timescale 1ns/1ps
module dgoc_engine_checker (
   input wire         mclk_in,
   input wire         srst_in,
   input wire         ce_in,
   input wire         wr_en_in,
   input wire         rd_en_in,
   input wire [1:0]   ch_sel_in,
   input wire [7:0]   addr_in,
   input wire [15:0]  wdata_in,
   input wire [15:0]  rdata_out,
   input wire         rdata_valid_out,
   input wire         busy_out,
   input wire         word_update_out,
   input wire [127:0] corrected_dac_word_out
);
wire tk = ce_in && wr_en_in && !busy_out;
wire dw = tk && addr_in < 8'h04 && ch_sel_in != 2'b00;
reg  cal;
// mirror of the calibration enable bit
always @(posedge mclk_in) begin
   if (srst_in) cal <= 1'b1;
   else if (tk && addr_in == 8'h11) cal <= wdata_in[0];
end
default clocking @(posedge mclk_in); endclocking
default disable iff (srst_in);
read_answer_a : assert property (ce_in && rd_en_in |=> rdata_valid_out)
   else $error("read not answered");
rdata_hold_a : assert property (!rdata_valid_out |-> $stable(rdata_out))
   else $error("read data moved");
dual_update_a : assert property (dw && ch_sel_in == 2'b11 |=>
   busy_out && word_update_out ##1 !busy_out && word_update_out) else $error("dual bad");
single_update_a : assert property (dw |=> word_update_out)
   else $error("no update");
trim_quiet_a : assert property (tk && addr_in >= 8'h11 |=> !word_update_out)
   else $error("trim write updated");
nochan_quiet_a : assert property (tk && addr_in < 8'h04 && ch_sel_in == 2'b00
   |=> !word_update_out)
   else $error("no channel yet updated");
word_hold_a : assert property (!word_update_out |-> $stable(corrected_dac_word_out))
   else $error("word moved");
bypass_raw_a : assert property (dw && !cal && ch_sel_in == 2'b01 && addr_in == 8'h00
   |=> corrected_dac_word_out[15:0] == $past(wdata_in)) else $error("bypass not raw");
cover property (dw && ch_sel_in == 2'b11);
cover property (dw && !cal);
cover property (rdata_valid_out);
endmodule
bind dgoc_engine dgoc_engine_checker u_dgoc_engine_checker (.mclk_in, .srst_in, .ce_in,
   .wr_en_in, .rd_en_in, .ch_sel_in, .addr_in, .wdata_in, .rdata_out, .rdata_valid_out,
   .busy_out, .word_update_out, .corrected_dac_word_out);

//--- test/dgoc_host.sv
// host model driving the engine register port
// assumes the same clock as the engine; drives just after each edge
`timescale 1ns/1ps
module dgoc_host (
   input  wire        mclk_in,
   output reg         wr_en_out,
   output reg         rd_en_out,
   output reg  [1:0]  ch_sel_out,
   output reg  [7:0]  addr_out,
   output reg  [15:0] wdata_out,
   input  wire [15:0] rdata_in,
   input  wire        rdata_valid_in
);
initial begin
   wr_en_out = 1'b0;
   rd_en_out = 1'b0;
   ch_sel_out = 2'b00;
   addr_out = 8'h00;
   wdata_out = 16'h0000;
end
task put(input w, input r, input [1:0] c, input [7:0] a, input [15:0] d);
   begin
      @(posedge mclk_in);
      #1;
      wr_en_out = w;
      rd_en_out = r;
      ch_sel_out = c;
      addr_out = a;
      // idle data is the complement of the given word, so a write's idle cycle never repeats it
      wdata_out = w ? d : ~d;
   end
endtask
// trims and mode are written before the input word by the caller
task wr(input [1:0] c, input [7:0] a, input [15:0] d);
   begin
      put(1'b1, 1'b0, c, a, d);
      put(1'b0, 1'b0, c, a, d);
   end
endtask
task rd(input [1:0] c, input [7:0] a, output [15:0] q, output v);
   begin
      put(1'b0, 1'b1, c, a, 16'h0000);
      put(1'b0, 1'b0, c, a, 16'h0000);
      q = rdata_in;
      v = rdata_valid_in;
   end
endtask
endmodule

//--- test/dgoc_engine_bench.sv
// self-checking bench for the correction engine
// assumes dgoc_host as the register port master
`timescale 1ns/1ps
module dgoc_engine_bench;
reg          mclk_in = 1'b0;
reg          srst_in;
wire         wr, rd, rv, bz, up;
wire [1:0]   cs;
wire [7:0]   ad;
wire [15:0]  wd, rq;
wire [127:0] wo;
integer      miscompares = 0;
integer      checks_done = 0;
integer      i;
reg  [15:0]  q;
reg          v;
reg          ce = 1'b1;
always #12.5 mclk_in = ~mclk_in;
dgoc_engine u_dgoc_engine (.mclk_in(mclk_in), .srst_in(srst_in), .ce_in(ce),
   .wr_en_in(wr), .rd_en_in(rd), .ch_sel_in(cs), .addr_in(ad), .wdata_in(wd),
   .rdata_out(rq), .rdata_valid_out(rv), .busy_out(bz), .word_update_out(up),
   .corrected_dac_word_out(wo));
dgoc_host u_dgoc_host (.mclk_in(mclk_in), .wr_en_out(wr), .rd_en_out(rd), .ch_sel_out(cs),
   .addr_out(ad), .wdata_out(wd), .rdata_in(rq), .rdata_valid_in(rv));
////////////////////////////////////////////////////////////////////////////////
task final_report;
   begin
      if (miscompares == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   end
endtask
task chk(input string n, input [15:0] e, input [15:0] g);
   begin
      checks_done = checks_done + 1;
      if (g !== e) begin
         miscompares = miscompares + 1;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   end
endtask
task rchk(input [1:0] c, input [7:0] a, input [15:0] e);
   begin
      u_dgoc_host.rd(c, a, q, v);
      chk($sformatf("valid %h", a), 16'h0001, {15'h0000, v});
      chk($sformatf("read %h/%h", c, a), e, q);
   end
endtask
task rst;
   begin
      srst_in = 1'b1;
      repeat (5) @(posedge mclk_in);
      #1;
      srst_in = 1'b0;
   end
endtask
initial begin
   #1000000;
   miscompares = miscompares + 1;
   final_report;
end
initial begin
   rst;
   for (i = 0; i < 8; i = i + 1) begin
      rchk(2'b01, 8'h40 + i[7:0], 16'hffff);
      rchk(2'b10, 8'h60 + i[7:0], 16'h8000);
   end
   rchk(2'b01, 8'h11, 16'h0001);
   rchk(2'b01, 8'h30, 16'h0000);
   u_dgoc_host.wr(2'b01, 8'h00, 16'h1234);
   rchk(2'b01, 8'h00, 16'h1234);
   u_dgoc_host.wr(2'b01, 8'h41, 16'h7fff);
   u_dgoc_host.wr(2'b01, 8'h61, 16'h8010);
   u_dgoc_host.wr(2'b01, 8'h01, 16'hc000);
   rchk(2'b01, 8'h01, 16'h6010);
   chk("dac word 1", 16'h6010, wo[31:16]);
   u_dgoc_host.wr(2'b01, 8'h01, 16'h0003);
   rchk(2'b01, 8'h01, 16'h0011);
   u_dgoc_host.wr(2'b01, 8'h41, 16'h1234);
   rchk(2'b01, 8'h01, 16'h0011);
   u_dgoc_host.wr(2'b01, 8'h60, 16'h0000);
   u_dgoc_host.wr(2'b01, 8'h00, 16'h0001);
   rchk(2'b01, 8'h00, 16'h0000);
   u_dgoc_host.wr(2'b01, 8'h60, 16'hffff);
   u_dgoc_host.wr(2'b01, 8'h00, 16'hffff);
   rchk(2'b01, 8'h00, 16'hffff);
   u_dgoc_host.wr(2'b01, 8'h45, 16'h3fff);
   u_dgoc_host.wr(2'b01, 8'h12, 16'h0002);
   rchk(2'b01, 8'h12, 16'h0002);
   rchk(2'b10, 8'h12, 16'h0000);
   rchk(2'b01, 8'h01, 16'h0011);
   u_dgoc_host.wr(2'b01, 8'h01, 16'hc000);
   rchk(2'b01, 8'h01, 16'h3000);
   // quarter and three-quarter scale points pass unchanged with default trims
   u_dgoc_host.wr(2'b01, 8'h02, 16'h4000);
   rchk(2'b01, 8'h02, 16'h4000);
   u_dgoc_host.wr(2'b01, 8'h03, 16'hc000);
   rchk(2'b01, 8'h03, 16'hc000);
   u_dgoc_host.put(1'b1, 1'b0, 2'b11, 8'h01, 16'h8000);
   u_dgoc_host.put(1'b1, 1'b0, 2'b01, 8'h01, 16'hdead);
   u_dgoc_host.put(1'b0, 1'b0, 2'b01, 8'h01, 16'h0000);
   rchk(2'b01, 8'h01, 16'h2000);
   rchk(2'b10, 8'h01, 16'h8000);
   chk("dac word 5", 16'h8000, wo[95:80]);
   chk("dac word 2", 16'h4000, wo[47:32]);
   u_dgoc_host.wr(2'b01, 8'h11, 16'h0000);
   u_dgoc_host.wr(2'b01, 8'h00, 16'hc000);
   rchk(2'b01, 8'h00, 16'hc000);
   u_dgoc_host.wr(2'b10, 8'h01, 16'h4321);
   rchk(2'b10, 8'h01, 16'h4321);
   // a write to dac word 0 while the clock enable is low must leave that word alone
   @(posedge mclk_in);
   #1;
   ce = 1'b0;
   u_dgoc_host.wr(2'b01, 8'h00, 16'h5555);
   @(posedge mclk_in);
   #1;
   ce = 1'b1;
   rchk(2'b01, 8'h00, 16'hc000);
   chk("dac word 0", 16'hc000, wo[15:0]);
   rst;
   rchk(2'b01, 8'h45, 16'hffff);
   rchk(2'b01, 8'h01, 16'h0000);
   rchk(2'b01, 8'h11, 16'h0001);
   final_report;
end
endmodule
